/* ccr_params.svh */
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
// Peripheral base and register offset
`define CCR_BASE_ADDR 32'h4001_001C
`define CCR_CS_OFFSET 32'h0000_0000
// Control/status field positions
`define CCR_EN_BIT 0
`define CCR_SW_BIT 1
`define CCR_MODE_LSB 2
`define CCR_MSEL_LSB 4
`define CCR_OSEL_LSB 8
`define CCR_PL_BIT 11
`define CCR_HST_LSB 12
`define CCR_OUT_BIT 14
`define CCR_LK_BIT 15
// Writable bits of the control/status word (bit 7 and bit 14 excluded)
`define CCR_WR_MASK 16'hBF7F
`define CCR_CS_RESET 16'h0000
// Output route codes
`define CCR_OSEL_NONE 3'h0
`define CCR_OSEL_T0_BRK 3'h1
`define CCR_OSEL_T0_CAP 3'h2
`define CCR_OSEL_T0_CLR 3'h3
`define CCR_OSEL_T2_CAP 3'h6
`define CCR_OSEL_T2_CLR 3'h7
`endif

/* ccr_pkg.sv */
package ccr_pkg;
	typedef enum logic [1:0] {
		SP_FAST, SP_MEDIUM, SP_LOW, SP_ULTRA_LOW
	} ccr_speed_t;
	typedef enum logic [1:0] {
		HY_NONE, HY_LOW, HY_MEDIUM, HY_HIGH
	} ccr_hyst_t;
	typedef enum logic [2:0] {
		IM_QUARTER, IM_HALF, IM_THREE_QUARTER, IM_FULL,
		IM_PIN_A4, IM_PIN_A5, IM_PIN_A0, IM_PIN_A2
	} ccr_minus_t;
	// Analog front-end settings
	typedef struct packed {
		logic enable;
		logic input_switch;
		ccr_speed_t speed_power_select;
		ccr_minus_t minus_select;
		ccr_hyst_t hysteresis_level;
	} ccr_analog_t;
	// Timer-side destinations
	typedef struct packed {
		logic first_timer_break;
		logic first_timer_capture0;
		logic first_timer_ref_clear;
		logic third_timer_capture0;
		logic third_timer_ref_clear;
	} ccr_timer_route_t;
endpackage

/* ccr_comparator_control_routing.sv */
`timescale 1ns/100ps
`include "ccr_params.svh"
module ccr_comparator_control_routing (
	// Clock and shared reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_cfg_clk_en,
	// Register port
	input wire logic i_sel,
	input wire logic i_wr,
	input wire logic [31:0] i_addr,
	input wire logic [31:0] i_wdata,
	output logic [31:0] o_rdata,
	// Analog core
	input wire logic i_raw_out,
	output ccr_pkg::ccr_analog_t o_analog,
	// Destinations
	output logic o_pin_out,
	output logic o_external_event_line,
	output ccr_pkg::ccr_timer_route_t o_timer_route
);
	logic [15:0] cs_reg;
	logic [15:0] cs_next;
	logic sync1_reg;
	logic sync2_reg;
	logic hit;
	logic pol_out;
	logic [2:0] osel;

	function automatic logic addr_hit(input logic [31:0] a);
		addr_hit = (a == (`CCR_BASE_ADDR + `CCR_CS_OFFSET));
	endfunction

	// Access qualified by shared clock enable
	assign hit = i_sel && i_cfg_clk_en && addr_hit(i_addr);

	always_comb begin
		cs_next = cs_reg;
		if (hit && i_wr && !cs_reg[`CCR_LK_BIT]) begin
			cs_next = (i_wdata[15:0] & `CCR_WR_MASK) | (cs_reg & ~`CCR_WR_MASK);
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cs_reg <= `CCR_CS_RESET;
		end else begin
			cs_reg <= cs_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
		end else begin
			sync1_reg <= i_raw_out;
			sync2_reg <= sync1_reg;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_rdata <= 32'h0000_0000;
		end else if (hit && !i_wr) begin
			o_rdata <= {16'h0000, cs_reg[15], sync2_reg, cs_reg[13:0]};
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_analog <= '0;
		end else begin
			o_analog.enable <= cs_next[`CCR_EN_BIT];
			o_analog.input_switch <= cs_next[`CCR_SW_BIT];
			o_analog.speed_power_select <=
				ccr_pkg::ccr_speed_t'(cs_next[`CCR_MODE_LSB +: 2]);
			o_analog.minus_select <=
				ccr_pkg::ccr_minus_t'(cs_next[`CCR_MSEL_LSB +: 3]);
			o_analog.hysteresis_level <=
				ccr_pkg::ccr_hyst_t'(cs_next[`CCR_HST_LSB +: 2]);
		end
	end

	// Signal path needs no clock for deep sleep
	assign pol_out = i_raw_out ^ cs_reg[`CCR_PL_BIT];
	assign osel = cs_reg[`CCR_OSEL_LSB +: 3];
	assign o_pin_out = pol_out;
	assign o_external_event_line = pol_out;
	always_comb begin
		o_timer_route = '0;
		unique case (osel)
			`CCR_OSEL_T0_BRK: o_timer_route.first_timer_break = pol_out;
			`CCR_OSEL_T0_CAP: o_timer_route.first_timer_capture0 = pol_out;
			`CCR_OSEL_T0_CLR: o_timer_route.first_timer_ref_clear = pol_out;
			`CCR_OSEL_T2_CAP: o_timer_route.third_timer_capture0 = pol_out;
			`CCR_OSEL_T2_CLR: o_timer_route.third_timer_ref_clear = pol_out;
			default: o_timer_route = '0;
		endcase
	end

	a_lock_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$past(cs_reg[`CCR_LK_BIT]) |-> cs_reg == $past(cs_reg))
		else $error("locked word changed");
	a_lock_sticky: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[`CCR_LK_BIT] |=> cs_reg[`CCR_LK_BIT])
		else $error("lock cleared");
	a_write_takes: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && i_wr && !cs_reg[`CCR_LK_BIT] |=>
		cs_reg[11:8] == $past(i_wdata[11:8]))
		else $error("write lost");
	a_polarity_path: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_pin_out == (i_raw_out ^ cs_reg[`CCR_PL_BIT]))
		else $error("polarity wrong");
	a_event_line: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_external_event_line == o_pin_out)
		else $error("event line mismatch");
	a_route_none: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		osel == `CCR_OSEL_NONE || osel == 3'h4 || osel == 3'h5 |->
		o_timer_route == '0)
		else $error("route leak");
	a_route_break: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		osel == `CCR_OSEL_T0_BRK |-> o_timer_route.first_timer_break == pol_out)
		else $error("break route wrong");
	a_sync_delay: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		##2 hit && !i_wr |=> o_rdata[`CCR_OUT_BIT] == $past(i_raw_out, 3))
		else $error("status sync wrong");

	// Register port behaviour
	a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!(hit && !i_wr) |=> o_rdata == 32'h0000_0000)
		else $error("read data not cleared");

	a_rdata_upper: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_rdata[31:16] == 16'h0000)
		else $error("upper read bits set");

	a_rdata_rsvd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_rdata[7] == 1'b0)
		else $error("reserved read bit set");

	a_status_live: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && !i_wr |=> o_rdata[`CCR_OUT_BIT] == $past(sync2_reg))
		else $error("status bit not synced value");

	a_read_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && !i_wr |=> cs_reg == $past(cs_reg))
		else $error("read changed word");

	a_addr_decode: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit |-> i_addr == `CCR_BASE_ADDR)
		else $error("wrong address decoded");

	a_miss_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!hit |=> cs_reg == $past(cs_reg))
		else $error("word changed without access");

	a_clken_blocks: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_cfg_clk_en |=> cs_reg == $past(cs_reg))
		else $error("access without clock enable");

	a_status_ro: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[`CCR_OUT_BIT] == 1'b0 && cs_reg[7] == 1'b0)
		else $error("read-only bits stored");

	// Write protection
	a_lock_sets: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && i_wr && !cs_reg[`CCR_LK_BIT] && i_wdata[`CCR_LK_BIT] |=> cs_reg[`CCR_LK_BIT])
		else $error("lock not set");

	a_lock_ignores: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && i_wr && cs_reg[`CCR_LK_BIT] |=> cs_reg == $past(cs_reg))
		else $error("write through lock");

	a_write_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && i_wr && !cs_reg[`CCR_LK_BIT] |=> cs_reg[6:0] == $past(i_wdata[6:0]))
		else $error("low fields not written");

	a_write_hyst: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && i_wr && !cs_reg[`CCR_LK_BIT] |=> cs_reg[13:12] == $past(i_wdata[13:12]))
		else $error("hysteresis not written");

	a_write_pol: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		hit && i_wr && !cs_reg[`CCR_LK_BIT] |=> cs_reg[11] == $past(i_wdata[11]))
		else $error("polarity not written");

	// Analog settings follow the stored word
	a_enable_field: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_analog.enable == cs_reg[`CCR_EN_BIT])
		else $error("enable mismatch");

	a_switch_field: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_analog.input_switch == cs_reg[`CCR_SW_BIT])
		else $error("switch mismatch");

	a_speed_fast: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[3:2] == 2'b00 |-> o_analog.speed_power_select == ccr_pkg::SP_FAST)
		else $error("fast mode wrong");

	a_speed_slow: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[3:2] == 2'b11 |-> o_analog.speed_power_select == ccr_pkg::SP_ULTRA_LOW)
		else $error("slow mode wrong");

	a_minus_field: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		3'(o_analog.minus_select) == cs_reg[6:4])
		else $error("minus select mismatch");

	a_hyst_none: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[13:12] == 2'b00 |-> o_analog.hysteresis_level == ccr_pkg::HY_NONE)
		else $error("hysteresis not off");

	a_hyst_high: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[13:12] == 2'b11 |-> o_analog.hysteresis_level == ccr_pkg::HY_HIGH)
		else $error("hysteresis not high");

	// Output routing
	a_route_cap0: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		osel == `CCR_OSEL_T0_CAP |-> o_timer_route.first_timer_capture0 == pol_out)
		else $error("first capture route wrong");

	a_route_clr0: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		osel == `CCR_OSEL_T0_CLR |-> o_timer_route.first_timer_ref_clear == pol_out)
		else $error("first clear route wrong");

	a_route_cap2: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		osel == `CCR_OSEL_T2_CAP |-> o_timer_route.third_timer_capture0 == pol_out)
		else $error("third capture route wrong");

	a_route_clr2: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		osel == `CCR_OSEL_T2_CLR |-> o_timer_route.third_timer_ref_clear == pol_out)
		else $error("third clear route wrong");

	a_route_single: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$onehot0(o_timer_route))
		else $error("more than one route");

	a_route_and_pin: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_timer_route != '0 |-> o_pin_out)
		else $error("pin lost while routed");

	// Polarity reaches every destination
	a_pin_plain: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!cs_reg[`CCR_PL_BIT] |-> o_pin_out == i_raw_out)
		else $error("pin not plain");

	a_pin_invert: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[`CCR_PL_BIT] |-> o_pin_out == !i_raw_out)
		else $error("pin not inverted");

	a_break_invert: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[`CCR_PL_BIT] && osel == `CCR_OSEL_T0_BRK |->
		o_timer_route.first_timer_break == !i_raw_out)
		else $error("break not inverted");

	a_event_invert: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		cs_reg[`CCR_PL_BIT] |-> o_external_event_line == !i_raw_out)
		else $error("event not inverted");

	// Synchroniser stages
	a_sync_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!$past(i_sys_rst) |-> sync1_reg == $past(i_raw_out))
		else $error("first stage wrong");

	a_sync_second: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!$past(i_sys_rst) |-> sync2_reg == $past(sync1_reg))
		else $error("second stage wrong");
endmodule // ccr_comparator_control_routing

/* ccr_analog_model.sv */
`timescale 1ns/100ps
// Analog core stand-in: output high only while enabled and above threshold
module ccr_analog_model (
	// Stimulus and settings
	input wire logic i_level,
	input wire ccr_pkg::ccr_analog_t i_analog,
	// Raw comparator output
	output logic o_raw_out
);
	assign o_raw_out = i_analog.enable & i_level;
endmodule // ccr_analog_model

/* testbench.sv */
`timescale 1ns/100ps
`include "ccr_params.svh"
module testbench;
	localparam logic [31:0] base = `CCR_BASE_ADDR;
	logic i_clk = 0, i_sys_rst = 1, i_cfg_clk_en = 1, i_sel = 0, i_wr = 0, i_raw_out, lvl = 0;
	logic [31:0] i_addr = base, i_wdata = 0, o_rdata;
	logic o_pin_out, o_ev;
	logic [4:0] er;
	ccr_pkg::ccr_analog_t o_analog;
	ccr_pkg::ccr_timer_route_t o_tr;
	int fails = 0, n_tests = 0;
	initial forever #4 i_clk = ~i_clk;
	ccr_comparator_control_routing dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_cfg_clk_en(i_cfg_clk_en), .i_sel(i_sel), .i_wr(i_wr), .i_addr(i_addr),
		.i_wdata(i_wdata), .o_rdata(o_rdata), .i_raw_out(i_raw_out), .o_analog(o_analog),
		.o_pin_out(o_pin_out), .o_external_event_line(o_ev), .o_timer_route(o_tr));
	ccr_analog_model model_u (.i_level(lvl), .i_analog(o_analog), .o_raw_out(i_raw_out));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge i_clk);
		i_sel = 1; i_wr = 1; i_addr = a; i_wdata = d;
		@(negedge i_clk);
		i_sel = 0;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] exp);
		@(negedge i_clk);
		i_sel = 1; i_wr = 0; i_addr = a;
		@(negedge i_clk);
		i_sel = 0;
		chk(o_rdata, exp);
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#20000 fails++;
		tally_and_finish;
	end
	initial begin
		repeat (5) @(posedge i_clk);
		@(negedge i_clk) i_sys_rst = 0;
		rd(base, 0);
		wr(base, 32'h0001_70FD);
		chk(32'(o_analog), 32'h0000_017F);
		lvl = 1;
		repeat (3) @(negedge i_clk);
		rd(base, 32'h0000_707D);
		$display("test fields done");
		for (int p = 0; p < 2; p++) for (int c = 0; c < 8; c++) begin
			wr(base, 32'h1 | (c << 8) | (p << 11));
			case (c)
				1: er = 5'h10;
				2: er = 5'h08;
				3: er = 5'h04;
				6: er = 5'h02;
				7: er = 5'h01;
				default: er = 5'h00;
			endcase
			chk(32'(o_tr), p ? 0 : 32'(er));
			chk(32'({o_pin_out, o_ev}), p ? 0 : 3);
		end
		lvl = 0;
		#1 chk(32'({o_pin_out, o_ev, o_tr}), 32'h0000_0061);
		chk(32'(o_analog), 32'h0000_0100);
		$display("test routes done");
		wr(base + 4, 32'h0000_0001);
		rd(base + 4, 0);
		i_cfg_clk_en = 0;
		wr(base, 0);
		i_cfg_clk_en = 1;
		rd(base, 32'h0000_0F01);
		wr(base, 32'h0000_8001);
		wr(base, 0);
		rd(base, 32'h0000_8001);
		@(negedge i_clk) i_sys_rst = 1;
		@(negedge i_clk) i_sys_rst = 0;
		rd(base, 0);
		$display("test lock done");
		tally_and_finish;
	end
endmodule // testbench
